// ==== bench/mdip_pin_board.sv ====
`timescale 1ns/1ns
`default_nettype none
module mdip_pin_board #(
    parameter int unsigned W = 8
) (
    // device side
    input  wire logic [W-1:0] drive_in,
    input  wire logic [W-1:0] oe_in,
    // board side
    input  wire logic [W-1:0] ext_in,
    output logic      [W-1:0] pin_out
);
    // a driven pin shows the device value, a released one the board level
    always_comb
    begin
        for (int i = 0; i < W; i++)
        begin
            pin_out[i] = oe_in[i] ? drive_in[i] : ext_in[i];
        end
    end
endmodule
`default_nettype wire

// ==== bench/mdip_ports_tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module mdip_ports_tb_top;
    logic        clk;
    logic        rst;
    logic [1:0]  mode;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [1:0]  bresp, rresp;
    logic [15:0] ab_in, ab_out, ab_oe, ab_ext, gh_in, gh_out, gh_oe, gh_ext;
    logic [7:0]  e_in, e_out, e_oe, e_ext;
    logic [33:0] exp_q[$];
    logic [15:0] d;
    logic [7:0]  e;
    logic [3:0]  strb;
    int          n_mismatch;
    int          n_compared;

    mdip_ports mdip_ports_inst (
        .clk_sys_in(clk), .sys_rst_in(rst), .bus_mode_in(mode),
        .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
        .s_axi_wdata_in(wdata), .s_axi_wstrb_in(strb), .s_axi_wvalid_in(wvalid),
        .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
        .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
        .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
        .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
        .first_pair_pin_in(ab_in), .first_pair_pin_out(ab_out), .first_pair_pin_oe_out(ab_oe),
        .second_pair_pin_in(gh_in), .second_pair_pin_out(gh_out),
        .second_pair_pin_oe_out(gh_oe),
        .fifth_port_pin_in(e_in), .fifth_port_pin_out(e_out), .fifth_port_pin_oe_out(e_oe));
    mdip_pin_board #(.W(16)) board_ab (.drive_in(ab_out), .oe_in(ab_oe), .ext_in(ab_ext),
        .pin_out(ab_in));
    mdip_pin_board #(.W(16)) board_gh (.drive_in(gh_out), .oe_in(gh_oe), .ext_in(gh_ext),
        .pin_out(gh_in));
    mdip_pin_board #(.W(8)) board_e (.drive_in(e_out), .oe_in(e_oe), .ext_in(e_ext),
        .pin_out(e_in));

    task automatic chk(input logic [33:0] seen, input logic [33:0] expv);
        n_compared++;
        if (seen !== expv)
        begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, expv);
        end
    endtask

    task automatic print_verdict();
        if (n_mismatch == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
        exp_q.push_back({er, 32'h0});
        awaddr  <= a;
        wdata   <= v;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        forever
        begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready)
            begin
                bready <= 1'b0;
                break;
            end
        end
        // one idle edge, so the next call never re-raises bready in this time step
        @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [33:0] expv);
        exp_q.push_back(expv);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        forever
        begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready)
            begin
                rready <= 1'b0;
                break;
            end
        end
        // one idle edge, so the next call never re-raises rready in this time step
        @(posedge clk);
    endtask

    task automatic set_mode(input logic [1:0] m);
        mode <= m;
        repeat (3) @(posedge clk);
    endtask

    // results are judged here, in the order the requests were issued
    always @(posedge clk)
    begin
        if (bvalid && bready) chk({bresp, 32'h0}, exp_q.pop_front());
        if (rvalid && rready) chk({rresp, rdata}, exp_q.pop_front());
    end

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        print_verdict();
    end

    initial
    begin
        {rst, awvalid, wvalid, bready, arvalid, rready} = 6'h3F;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, araddr, wdata} = 48'h0;
        strb = 4'hF;
        mode = mdip_pkg::MODE_SINGLE;
        void'($urandom(27));
        ab_ext = 16'($urandom());
        gh_ext = 16'($urandom());
        e_ext  = 8'($urandom());
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk({18'h0, gh_oe}, 34'h0);
        rd(8'h08, 34'h0);
        rd(8'h04, {18'h0, gh_ext});
        d = 16'($urandom());
        wr(8'h08, 32'h0000FFFF, mdip_pkg::RESP_OKAY);
        wr(8'h04, {16'h0, d}, mdip_pkg::RESP_OKAY);
        rd(8'h04, {18'h0, d});
        repeat (3) @(posedge clk);
        chk({gh_out, gh_oe}, {2'b0, d, 16'hFFFF});
        // only the upper byte lane is enabled, the lower byte keeps its value
        strb <= 4'h2;
        wr(8'h04, {16'h0, ~d}, mdip_pkg::RESP_OKAY);
        strb <= 4'hF;
        rd(8'h04, {18'h0, ~d[15:8], d[7:0]});
        set_mode(mdip_pkg::MODE_PARTIAL);
        chk({18'h0, gh_oe}, 34'h000FF);
        set_mode(mdip_pkg::MODE_EXPANDED);
        chk({18'h0, gh_oe}, 34'h0);
        set_mode(mdip_pkg::MODE_SINGLE);
        // upper byte of the shared direction word is tried alone
        wr(8'h08, 32'h0000FF00, mdip_pkg::RESP_OKAY);
        repeat (3) @(posedge clk);
        chk({18'h0, gh_oe}, 34'h0FF00);
        d = 16'($urandom());
        wr(8'h14, 32'h1, mdip_pkg::RESP_OKAY);
        wr(8'h00, {16'h0, d}, mdip_pkg::RESP_OKAY);
        rd(8'h00, {18'h0, d});
        repeat (3) @(posedge clk);
        chk({ab_out, ab_oe}, {2'b0, d, 16'hFFFF});
        set_mode(mdip_pkg::MODE_PARTIAL);
        chk({18'h0, ab_oe}, 34'h0);
        e = 8'($urandom());
        wr(8'h18, 32'hFF, mdip_pkg::RESP_OKAY);
        wr(8'h0C, {16'hA5C3, 8'h7E, e}, mdip_pkg::RESP_OKAY);
        rd(8'h10, {26'h0, e});
        wr(8'h10, {24'h0, ~e}, mdip_pkg::RESP_OKAY);
        rd(8'h0C, {26'h0, ~e});
        chk({18'h0, e_out, e_oe}, {18'h0, ~e, 8'hFF});
        set_mode(mdip_pkg::MODE_EMULATOR);
        wr(8'h00, 32'h0, mdip_pkg::RESP_SLVERR);
        wr(8'h0C, 32'h0, mdip_pkg::RESP_SLVERR);
        rd(8'h00, {mdip_pkg::RESP_SLVERR, 32'h0});
        rd(8'h10, {mdip_pkg::RESP_SLVERR, 32'h0});
        wr(8'h18, 32'h0, mdip_pkg::RESP_SLVERR);
        set_mode(mdip_pkg::MODE_SINGLE);
        rd(8'h00, {18'h0, d});
        rd(8'h10, {26'h0, ~e});
        rd(8'h20, {mdip_pkg::RESP_DECERR, 32'h0});
        wr(8'h20, 32'hFFFF, mdip_pkg::RESP_DECERR);
        // the mode word is read only: the write is answered and dropped
        wr(8'h1C, 32'h3, mdip_pkg::RESP_OKAY);
        for (int m = 0; m < 4; m++)
        begin
            set_mode(2'(m));
            rd(8'h1C, {2'b0, 30'h0, 2'(m)});
            chk({26'h0, e_oe}, 34'h0FF);
        end
        // a second reset in mid-run must clear directions that are now set
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk({18'h0, gh_oe}, 34'h0);
        rd(8'h08, 34'h0);
        rd(8'h14, 34'h0);
        repeat (3) @(posedge clk);
        print_verdict();
    end
endmodule
`default_nettype wire

// ==== design/mdip_pin_cell.sv ====
`timescale 1ns/1ns
`default_nettype none
module mdip_pin_cell #(
    parameter int unsigned W = 8
) (
    // clock and reset
    input  wire logic         clk_sys_in,
    input  wire logic         sys_rst_in,
    // control from the register file, and the port enable from the mode decode
    input  wire logic         port_en_in,
    input  wire logic [W-1:0] latch_in,
    input  wire logic [W-1:0] dir_in,
    // pin side
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] pin_drive_out,
    output logic      [W-1:0] pin_oe_out,
    // value software reads back
    output logic      [W-1:0] read_val_out
);

    typedef struct packed
    {
        logic [W-1:0] drive;
        logic [W-1:0] oe;
        logic [W-1:0] smp;
    } mdip_cell_t;

    mdip_cell_t r_ff;
    mdip_cell_t nxt_r;

    always_comb
    begin
        nxt_r       = r_ff;
        nxt_r.drive = latch_in;
        // a port not offered in this mode never drives its pins
        nxt_r.oe    = port_en_in ? dir_in : '0;
        nxt_r.smp   = pin_in;
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
        begin
            r_ff <= '0;
        end
        else
        begin
            r_ff <= nxt_r;
        end
    end

    assign pin_drive_out = r_ff.drive;
    assign pin_oe_out    = r_ff.oe;
    // outputs read back the latch, inputs read the sampled pin
    assign read_val_out  = (dir_in & latch_in) | (~dir_in & r_ff.smp);

endmodule
`default_nettype wire

// ==== design/mdip_pkg.sv ====
package mdip_pkg;

    // bus operating mode, sampled from the mode straps each cycle
    typedef enum logic [1:0]
    {
        MODE_SINGLE   = 2'b00,
        MODE_PARTIAL  = 2'b01,
        MODE_EXPANDED = 2'b10,
        MODE_EMULATOR = 2'b11
    } mdip_mode_t;

    typedef enum logic [3:0]
    {
        SEL_AB_DATA  = 4'b0000,
        SEL_GH_DATA  = 4'b0001,
        SEL_GH_DIR   = 4'b0010,
        SEL_E_DATA0  = 4'b0011,
        SEL_E_DATA1  = 4'b0100,
        SEL_AB_DIR   = 4'b0101,
        SEL_E_DIR    = 4'b0110,
        SEL_MODE     = 4'b0111,
        SEL_NONE     = 4'b1000
    } mdip_sel_t;

    localparam int unsigned ADDR_W      = 8;
    localparam int unsigned PORT_W      = 8;
    localparam int unsigned NUM_PORTS   = 5;

    // byte addresses of the register words
    localparam logic [7:0] OFF_AB_DATA  = 8'h00;
    localparam logic [7:0] OFF_GH_DATA  = 8'h04;
    localparam logic [7:0] OFF_GH_DIR   = 8'h08;
    localparam logic [7:0] OFF_E_DATA0  = 8'h0C;
    localparam logic [7:0] OFF_E_DATA1  = 8'h10;
    localparam logic [7:0] OFF_AB_DIR   = 8'h14;
    localparam logic [7:0] OFF_E_DIR    = 8'h18;
    localparam logic [7:0] OFF_MODE     = 8'h1C;

    // field positions inside the paired words
    localparam int unsigned UPPER_LSB   = 8;
    localparam int unsigned LOWER_LSB   = 0;

    localparam logic [15:0] DIR16_RST   = 16'h0000;
    localparam logic [7:0]  DIR8_RST    = 8'h00;
    localparam logic [15:0] DATA16_RST  = 16'h0000;
    localparam logic [7:0]  DATA8_RST   = 8'h00;

    localparam logic [1:0] RESP_OKAY    = 2'b00;
    localparam logic [1:0] RESP_SLVERR  = 2'b10;
    localparam logic [1:0] RESP_DECERR  = 2'b11;

endpackage

// ==== design/mdip_ports.sv ====
`timescale 1ns/1ns
`default_nettype none
module mdip_ports (
    // clock and reset
    input  wire logic        clk_sys_in,
    input  wire logic        sys_rst_in,
    // bus operating mode
    input  wire logic [1:0]  bus_mode_in,
    // axi4-lite write channels
    input  wire logic [7:0]  s_axi_awaddr_in,
    input  wire logic        s_axi_awvalid_in,
    output logic             s_axi_awready_out,
    input  wire logic [31:0] s_axi_wdata_in,
    input  wire logic [3:0]  s_axi_wstrb_in,
    input  wire logic        s_axi_wvalid_in,
    output logic             s_axi_wready_out,
    output logic [1:0]       s_axi_bresp_out,
    output logic             s_axi_bvalid_out,
    input  wire logic        s_axi_bready_in,
    // axi4-lite read channels
    input  wire logic [7:0]  s_axi_araddr_in,
    input  wire logic        s_axi_arvalid_in,
    output logic             s_axi_arready_out,
    output logic [31:0]      s_axi_rdata_out,
    output logic [1:0]       s_axi_rresp_out,
    output logic             s_axi_rvalid_out,
    input  wire logic        s_axi_rready_in,
    // first paired port pins
    input  wire logic [15:0] first_pair_pin_in,
    output logic [15:0]      first_pair_pin_out,
    output logic [15:0]      first_pair_pin_oe_out,
    // second paired port pins
    input  wire logic [15:0] second_pair_pin_in,
    output logic [15:0]      second_pair_pin_out,
    output logic [15:0]      second_pair_pin_oe_out,
    // fifth port pins
    input  wire logic [7:0]  fifth_port_pin_in,
    output logic [7:0]       fifth_port_pin_out,
    output logic [7:0]       fifth_port_pin_oe_out
);

    typedef struct packed
    {
        logic [15:0] ab_data;
        logic [15:0] gh_data;
        logic [15:0] gh_dir;
        logic        ab_dir;
        logic [7:0]  e_data;
        logic [7:0]  e_dir;
        logic        aw_got;
        logic        w_got;
        logic [7:0]  awaddr;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
    } mdip_state_t;

    mdip_state_t r_ff;
    mdip_state_t nxt_r;
    mdip_pkg::mdip_mode_t mode;
    logic [7:0]           lat   [mdip_pkg::NUM_PORTS];
    logic [7:0]           dir   [mdip_pkg::NUM_PORTS];
    logic [7:0]           pin_i [mdip_pkg::NUM_PORTS];
    logic [7:0]           pin_o [mdip_pkg::NUM_PORTS];
    logic [7:0]           oe    [mdip_pkg::NUM_PORTS];
    logic [7:0]           rv    [mdip_pkg::NUM_PORTS];
    logic                 en    [mdip_pkg::NUM_PORTS];
    logic                 aw_hs;
    logic                 w_hs;
    logic                 ar_hs;
    assign mode = mdip_pkg::mdip_mode_t'(bus_mode_in);
    function automatic mdip_pkg::mdip_sel_t decode(input logic [7:0] addr);
        unique case (addr)
            mdip_pkg::OFF_AB_DATA: decode = mdip_pkg::SEL_AB_DATA;
            mdip_pkg::OFF_GH_DATA: decode = mdip_pkg::SEL_GH_DATA;
            mdip_pkg::OFF_GH_DIR:  decode = mdip_pkg::SEL_GH_DIR;
            mdip_pkg::OFF_E_DATA0: decode = mdip_pkg::SEL_E_DATA0;
            mdip_pkg::OFF_E_DATA1: decode = mdip_pkg::SEL_E_DATA1;
            mdip_pkg::OFF_AB_DIR:  decode = mdip_pkg::SEL_AB_DIR;
            mdip_pkg::OFF_E_DIR:   decode = mdip_pkg::SEL_E_DIR;
            mdip_pkg::OFF_MODE:    decode = mdip_pkg::SEL_MODE;
            default:               decode = mdip_pkg::SEL_NONE;
        endcase
    endfunction
    // words closed to software while an emulator owns the pins
    function automatic logic emu_locked(input mdip_pkg::mdip_sel_t sel,
                                        input mdip_pkg::mdip_mode_t md);
        emu_locked = (md == mdip_pkg::MODE_EMULATOR) &&
                     (sel == mdip_pkg::SEL_AB_DATA || sel == mdip_pkg::SEL_E_DATA0 ||
                      sel == mdip_pkg::SEL_E_DATA1 || sel == mdip_pkg::SEL_E_DIR);
    endfunction
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] data,
                                            input logic [3:0]  strb);
        merge16[15:8] = strb[1] ? data[15:8] : old[15:8];
        merge16[7:0]  = strb[0] ? data[7:0]  : old[7:0];
    endfunction
    // port 0 first upper, 1 first lower, 2 third, 3 fourth, 4 fifth
    assign lat[0]   = r_ff.ab_data[15:8];
    assign lat[1]   = r_ff.ab_data[7:0];
    assign lat[2]   = r_ff.gh_data[15:8];
    assign lat[3]   = r_ff.gh_data[7:0];
    assign lat[4]   = r_ff.e_data;
    assign dir[0]   = {8{r_ff.ab_dir}};
    assign dir[1]   = {8{r_ff.ab_dir}};
    assign dir[2]   = r_ff.gh_dir[15:8];
    assign dir[3]   = r_ff.gh_dir[7:0];
    assign dir[4]   = r_ff.e_dir;
    assign en[0]    = (mode == mdip_pkg::MODE_SINGLE);
    assign en[1]    = (mode == mdip_pkg::MODE_SINGLE);
    // third port is given up in every mode but single-chip, so only single-chip means plain i/o
    assign en[2]    = (mode == mdip_pkg::MODE_SINGLE);
    assign en[3]    = (mode == mdip_pkg::MODE_SINGLE) ||
                      (mode == mdip_pkg::MODE_PARTIAL);
    assign en[4]    = 1'b1;
    assign pin_i[0] = first_pair_pin_in[15:8];
    assign pin_i[1] = first_pair_pin_in[7:0];
    assign pin_i[2] = second_pair_pin_in[15:8];
    assign pin_i[3] = second_pair_pin_in[7:0];
    assign pin_i[4] = fifth_port_pin_in;
    for (genvar p = 0; p < mdip_pkg::NUM_PORTS; p++)
    begin : g_port
        mdip_pin_cell #(
            .W (mdip_pkg::PORT_W)
        ) mdip_pin_cell_inst (
            .clk_sys_in    (clk_sys_in),
            .sys_rst_in    (sys_rst_in),
            .port_en_in    (en[p]),
            .latch_in      (lat[p]),
            .dir_in        (dir[p]),
            .pin_in        (pin_i[p]),
            .pin_drive_out (pin_o[p]),
            .pin_oe_out    (oe[p]),
            .read_val_out  (rv[p])
        );
    end

    assign aw_hs = s_axi_awvalid_in & r_ff.awready;
    assign w_hs  = s_axi_wvalid_in & r_ff.wready;
    assign ar_hs = s_axi_arvalid_in & r_ff.arready;
    always_comb
    begin
        mdip_pkg::mdip_sel_t wsel;
        mdip_pkg::mdip_sel_t rsel;
        nxt_r = r_ff;
        wsel  = mdip_pkg::SEL_NONE;
        rsel  = decode(s_axi_araddr_in);
        if (r_ff.bvalid && s_axi_bready_in)
        begin
            nxt_r.bvalid = 1'b0;
        end
        if (aw_hs)
        begin
            nxt_r.aw_got = 1'b1;
            nxt_r.awaddr = s_axi_awaddr_in;
        end
        if (w_hs)
        begin
            nxt_r.w_got = 1'b1;
            nxt_r.wdata = s_axi_wdata_in;
            nxt_r.wstrb = s_axi_wstrb_in;
        end
        // address and data may arrive in either order; commit once both are held
        if (nxt_r.aw_got && nxt_r.w_got && !nxt_r.bvalid)
        begin
            wsel         = decode(nxt_r.awaddr);
            nxt_r.aw_got = 1'b0;
            nxt_r.w_got  = 1'b0;
            nxt_r.bvalid = 1'b1;
            nxt_r.bresp  = mdip_pkg::RESP_OKAY;
            if (wsel == mdip_pkg::SEL_NONE)
            begin
                nxt_r.bresp = mdip_pkg::RESP_DECERR;
            end
            else if (emu_locked(wsel, mode))
            begin
                nxt_r.bresp = mdip_pkg::RESP_SLVERR;
            end
            else
            begin
                unique case (wsel)
                    mdip_pkg::SEL_AB_DATA:
                        nxt_r.ab_data = merge16(r_ff.ab_data, nxt_r.wdata, nxt_r.wstrb);
                    mdip_pkg::SEL_GH_DATA:
                        nxt_r.gh_data = merge16(r_ff.gh_data, nxt_r.wdata, nxt_r.wstrb);
                    mdip_pkg::SEL_GH_DIR:
                        nxt_r.gh_dir = merge16(r_ff.gh_dir, nxt_r.wdata, nxt_r.wstrb);
                    mdip_pkg::SEL_E_DATA0, mdip_pkg::SEL_E_DATA1:
                        nxt_r.e_data = nxt_r.wstrb[0] ? nxt_r.wdata[7:0] : r_ff.e_data;
                    mdip_pkg::SEL_AB_DIR:
                        nxt_r.ab_dir = nxt_r.wstrb[0] ? nxt_r.wdata[0] : r_ff.ab_dir;
                    mdip_pkg::SEL_E_DIR:
                        nxt_r.e_dir = nxt_r.wstrb[0] ? nxt_r.wdata[7:0] : r_ff.e_dir;
                    // mode word is read only; the write is acknowledged and dropped
                    mdip_pkg::SEL_MODE, mdip_pkg::SEL_NONE:
                        nxt_r.bresp = nxt_r.bresp;
                endcase
            end
        end
        if (r_ff.rvalid && s_axi_rready_in)
        begin
            nxt_r.rvalid = 1'b0;
        end
        if (ar_hs)
        begin
            nxt_r.rvalid = 1'b1;
            nxt_r.rresp  = mdip_pkg::RESP_OKAY;
            nxt_r.rdata  = 32'h0000_0000;
            if (rsel == mdip_pkg::SEL_NONE)
            begin
                nxt_r.rresp = mdip_pkg::RESP_DECERR;
            end
            else if (emu_locked(rsel, mode))
            begin
                nxt_r.rresp = mdip_pkg::RESP_SLVERR;
            end
            else
            begin
                unique case (rsel)
                    mdip_pkg::SEL_AB_DATA: nxt_r.rdata[15:0] = {rv[0], rv[1]};
                    mdip_pkg::SEL_GH_DATA: nxt_r.rdata[15:0] = {rv[2], rv[3]};
                    mdip_pkg::SEL_GH_DIR:  nxt_r.rdata[15:0] = r_ff.gh_dir;
                    mdip_pkg::SEL_E_DATA0, mdip_pkg::SEL_E_DATA1:
                        nxt_r.rdata[7:0] = rv[4];
                    mdip_pkg::SEL_AB_DIR:  nxt_r.rdata[0] = r_ff.ab_dir;
                    mdip_pkg::SEL_E_DIR:   nxt_r.rdata[7:0] = r_ff.e_dir;
                    mdip_pkg::SEL_MODE:    nxt_r.rdata[1:0] = bus_mode_in;
                    mdip_pkg::SEL_NONE:    nxt_r.rdata = 32'h0000_0000;
                endcase
            end
        end
        nxt_r.awready = !nxt_r.aw_got && !nxt_r.bvalid;
        nxt_r.wready  = !nxt_r.w_got && !nxt_r.bvalid;
        nxt_r.arready = !nxt_r.rvalid;
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
        begin
            r_ff         <= '0;
            r_ff.ab_data <= mdip_pkg::DATA16_RST;
            r_ff.gh_data <= mdip_pkg::DATA16_RST;
            r_ff.e_data  <= mdip_pkg::DATA8_RST;
            r_ff.gh_dir  <= mdip_pkg::DIR16_RST;
            r_ff.e_dir   <= mdip_pkg::DIR8_RST;
            r_ff.ab_dir  <= 1'b0;
            r_ff.awready <= 1'b1;
            r_ff.wready  <= 1'b1;
            r_ff.arready <= 1'b1;
        end
        else
        begin
            r_ff <= nxt_r;
        end
    end

    assign s_axi_awready_out      = r_ff.awready;
    assign s_axi_wready_out       = r_ff.wready;
    assign s_axi_bvalid_out       = r_ff.bvalid;
    assign s_axi_bresp_out        = r_ff.bresp;
    assign s_axi_arready_out      = r_ff.arready;
    assign s_axi_rvalid_out       = r_ff.rvalid;
    assign s_axi_rresp_out        = r_ff.rresp;
    assign s_axi_rdata_out        = r_ff.rdata;
    assign first_pair_pin_out     = {pin_o[0], pin_o[1]};
    assign first_pair_pin_oe_out  = {oe[0], oe[1]};
    assign second_pair_pin_out    = {pin_o[2], pin_o[3]};
    assign second_pair_pin_oe_out = {oe[2], oe[3]};
    assign fifth_port_pin_out     = pin_o[4];
    assign fifth_port_pin_oe_out  = oe[4];
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (sys_rst_in);

    a_ab_mode_gate: assert property (
        |first_pair_pin_oe_out |-> $past(bus_mode_in) == mdip_pkg::MODE_SINGLE)
        else $error("first pair driven outside single-chip mode");
    a_ab_shared_dir: assert property (
        first_pair_pin_oe_out == 16'h0000 || first_pair_pin_oe_out == 16'hFFFF)
        else $error("first pair direction split between pins");
    a_ab_word_pack: assert property (
        first_pair_pin_out == $past(r_ff.ab_data))
        else $error("first pair pins do not follow packed word");
    a_emu_refuse: assert property (
        ar_hs && emu_locked(decode(s_axi_araddr_in), mode)
        |=> s_axi_rvalid_out && s_axi_rresp_out == mdip_pkg::RESP_SLVERR
            && s_axi_rdata_out == 32'h0000_0000)
        else $error("locked read not refused in emulator mode");
    a_g_mode_gate: assert property (
        |second_pair_pin_oe_out[15:8] |-> $past(bus_mode_in) == mdip_pkg::MODE_SINGLE)
        else $error("third port driven outside single-chip mode");
    a_g_plain_io: assert property (
        $past(bus_mode_in) == mdip_pkg::MODE_SINGLE
        |-> second_pair_pin_oe_out[15:8] == $past(r_ff.gh_dir[15:8]))
        else $error("third port not plain i/o in single-chip mode");
    a_h_mode_gate: assert property (
        |second_pair_pin_oe_out[7:0] |-> $past(bus_mode_in) == mdip_pkg::MODE_SINGLE
        || $past(bus_mode_in) == mdip_pkg::MODE_PARTIAL)
        else $error("fourth port driven in wrong mode");
    a_h_dir_follow: assert property (
        second_pair_pin_oe_out[7:0] == ($past(en[3]) ? $past(r_ff.gh_dir[7:0]) : 8'h00))
        else $error("fourth port enable does not follow direction and mode");
    a_e_alias_eq: assert property (
        ar_hs && (decode(s_axi_araddr_in) == mdip_pkg::SEL_E_DATA0
        || decode(s_axi_araddr_in) == mdip_pkg::SEL_E_DATA1) && !emu_locked(mdip_pkg::SEL_E_DATA0, mode)
        |=> s_axi_rdata_out == {24'h00_0000, $past(rv[4])})
        else $error("fifth port alias reads differ");
    a_dir_reset: assert property (
        $fell(sys_rst_in) |-> r_ff.gh_dir == 16'h0000 && !r_ff.ab_dir)
        else $error("direction bits not clear after reset");

    c_write_done: cover property (s_axi_bvalid_out && s_axi_bready_in);
    c_emu_refused: cover property (s_axi_rvalid_out && s_axi_rresp_out == mdip_pkg::RESP_SLVERR);
    c_h_partial: cover property (|second_pair_pin_oe_out[7:0]
        && $past(bus_mode_in) == mdip_pkg::MODE_PARTIAL);
    c_ab_drive: cover property (first_pair_pin_oe_out == 16'hFFFF);

endmodule
`default_nettype wire
